// [design/afm_axis_fault_monitor.sv]
// Per-axis following-error and RMS overcurrent fault monitor with APB registers
//
// Overview of operation
// RULE_01: Following error is reference minus feedback position.
// RULE_02: Flag fault when error exceeds applicable threshold.
// RULE_03: Thresholds and checking kept per axis instance.
// RULE_04: Separate normal and critical following faults.
// RULE_05: Threshold picked by idle, cruise or accel state.
// RULE_06: Idle state uses both idle thresholds.
// RULE_07: Cruise state uses both cruise thresholds.
// RULE_08: Accel state uses both accel thresholds.
// RULE_09: Optional hold-off delay after state change.
// RULE_10: Accel-to-idle suppresses checks for idle delay.
// RULE_11: Accel-to-cruise suppresses checks for cruise delay.
// RULE_12: Critical thresholds reset 1000, normal thresholds 100.
// RULE_13: Allow bit gates the normal following fault.
// RULE_14: RMS fault after time-constant weighted heating.
// RULE_15: Drive and motor limits use own constants.
// RULE_16: Software keeps idle current below moving limit.
// RULE_17: RMS time constant given in milliseconds.
// RULE_18: Absolute error compared, either sign faults.
// RULE_19: Faults sticky until cleared; rising edge reported.
`timescale 1ns/100ps
`default_nettype none
`include "afm_params.svh"

module afm_axis_fault_monitor #(
    parameter int POS_W    = 32,
    parameter int MS_CYC   = `AFM_MS_CYCLES,
    parameter int RMS_FRAC = 16
) (
    // Clock and reset
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    // APB slave
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [11:0]        paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // Trajectory and feedback, same clock
    input  wire logic [POS_W-1:0]   ref_position_i,
    input  wire logic [POS_W-1:0]   feedback_position_i,
    input  wire logic [1:0]         motion_state_i,
    input  wire logic [15:0]        drive_command_level_i,
    // Fault outputs
    output logic                    following_fault_o,
    output logic                    critical_following_fault_o,
    output logic                    rms_fault_o,
    output logic                    fault_event_o,
    output logic                    irq_o
);

    localparam int ACC_W = 48;

    // Registers
    logic [31:0]        ctrl_q;
    logic [3:0]         status_q;
    logic [3:0]         mask_q;
    logic [POS_W-1:0]   crit_thr_q [3];
    logic [POS_W-1:0]   foll_thr_q [3];
    logic [15:0]        idle_holdoff_delay_q;
    logic [15:0]        cruise_holdoff_delay_q;
    logic [15:0]        drive_rms_limit_q;
    logic [15:0]        motor_rms_limit_q;
    logic [15:0]        drive_rms_time_constant_q;
    logic [15:0]        motor_rms_time_constant_q;

    // Datapath state
    logic signed [POS_W-1:0] err_q;
    logic [POS_W-1:0]   abs_err;
    afm_pkg::afm_motion_t state_q;
    afm_pkg::afm_motion_t state_now;
    logic [15:0]        holdoff_ms_q;
    logic [$clog2(MS_CYC+1)-1:0] ms_cnt_q;
    logic               ms_tick;
    logic               checking;
    logic               foll_hit;
    logic               crit_hit;
    logic [ACC_W-1:0]   drive_heat_q;
    logic [ACC_W-1:0]   motor_heat_q;
    logic               drive_hit;
    logic               motor_hit;
    logic [3:0]         events;

    wire wr_en = psel_i && penable_i && pwrite_i;

    // Unknown codes fall back to idle, the strictest assumption of rest
    always_comb begin
        case (motion_state_i)
            2'd1:    state_now = afm_pkg::AFM_CRUISE;
            2'd2:    state_now = afm_pkg::AFM_ACCEL;
            default: state_now = afm_pkg::AFM_IDLE;
        endcase
    end

    // One divider for both users keeps hold-off and heating in step
    // Millisecond tick shared by hold-off and RMS integration
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || ms_cnt_q == ($clog2(MS_CYC+1))'(MS_CYC - 1)) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 1'b1;
        end
    end
    assign ms_tick = (ms_cnt_q == ($clog2(MS_CYC+1))'(MS_CYC - 1));

    // Following error, registered
    // Wrapping subtraction stays right across position rollover
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            err_q <= '0;
        end else begin
            err_q <= $signed(ref_position_i - feedback_position_i); // RULE_01
        end
    end
    assign abs_err = err_q[POS_W-1] ? POS_W'(-err_q) : POS_W'(err_q); // RULE_18

    // Motion state tracking and hold-off
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q      <= afm_pkg::AFM_IDLE;
            holdoff_ms_q <= '0;
        end else begin
            state_q <= state_now;
            if (state_q == afm_pkg::AFM_ACCEL && state_now != afm_pkg::AFM_ACCEL
                && ctrl_q[`AFM_CTRL_DELAY_BIT]) begin // RULE_09
                if (state_now == afm_pkg::AFM_IDLE) begin
                    holdoff_ms_q <= idle_holdoff_delay_q; // RULE_10
                end else begin
                    holdoff_ms_q <= cruise_holdoff_delay_q; // RULE_11
                end
            end else if (state_q != state_now) begin
                // Any other change cancels a hold-off still running
                holdoff_ms_q <= '0;
            end else if (ms_tick && holdoff_ms_q != '0) begin
                holdoff_ms_q <= holdoff_ms_q - 1'b1;
            end
        end
    end
    // Hold-off granularity is one tick: it may end up to 1 ms early
    assign checking = (holdoff_ms_q == '0);

    // Threshold selection by motion state; one set per instance, one axis each
    function automatic logic [POS_W-1:0] thr_pick(
        input afm_pkg::afm_motion_t st,
        input logic [POS_W-1:0]     idle_thr,
        input logic [POS_W-1:0]     cruise_thr,
        input logic [POS_W-1:0]     accel_thr
    );
        case (st) // RULE_05
            afm_pkg::AFM_CRUISE: thr_pick = cruise_thr; // RULE_07
            afm_pkg::AFM_ACCEL:  thr_pick = accel_thr; // RULE_08
            default:             thr_pick = idle_thr; // RULE_06
        endcase
    endfunction

    // Both levels share one lookup so they always follow the same state
    always_comb begin
        foll_hit = abs_err > thr_pick(state_q, foll_thr_q[0], foll_thr_q[1], foll_thr_q[2]); // RULE_02 RULE_03
        crit_hit = abs_err > thr_pick(state_q, crit_thr_q[0], crit_thr_q[1], crit_thr_q[2]); // RULE_04
    end

    // First-order heating per ms: heat += (cmd^2 - heat) / tc, scaled by 2^RMS_FRAC.
    // Trip when heat passes lim^2, a delay of tc * -ln(1 - lim^2/cmd^2).
    // Bleed is taken before the drive is added, so the sum never leaves ACC_W bits.
    function automatic logic [ACC_W-1:0] heat_step(
        input logic [ACC_W-1:0] heat,
        input logic [15:0]      cmd,
        input logic [15:0]      tc
    );
        logic [ACC_W-1:0] tc_div;
        logic [ACC_W-1:0] drive_sq;
        logic [ACC_W-1:0] bleed;
        tc_div    = ACC_W'((tc == 16'h0000) ? 16'h0001 : tc);
        drive_sq  = (ACC_W'({cmd, RMS_FRAC'(0)}) * ACC_W'(cmd)) / tc_div;
        bleed     = heat / tc_div;
        heat_step = heat - bleed + drive_sq;
    endfunction

    function automatic logic [ACC_W-1:0] heat_limit(input logic [15:0] lim);
        heat_limit = ACC_W'({lim, RMS_FRAC'(0)}) * ACC_W'(lim);
    endfunction

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            drive_heat_q <= '0;
            motor_heat_q <= '0;
        end else if (ms_tick) begin // RULE_17
            drive_heat_q <= heat_step(drive_heat_q, drive_command_level_i,
                                      drive_rms_time_constant_q); // RULE_15
            motor_heat_q <= heat_step(motor_heat_q, drive_command_level_i,
                                      motor_rms_time_constant_q); // RULE_15
        end
    end
    assign drive_hit = drive_heat_q > heat_limit(drive_rms_limit_q); // RULE_14
    assign motor_hit = motor_heat_q > heat_limit(motor_rms_limit_q); // RULE_14

    // Hold-off gates only the following-error checks; RMS heating keeps running
    assign events = {motor_hit,
                     drive_hit,
                     checking && crit_hit,
                     checking && foll_hit && ctrl_q[`AFM_CTRL_ALLOW_BIT]}; // RULE_13

    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            status_q      <= '0;
            fault_event_o <= 1'b0;
        end else begin
            if (wr_en && paddr_i == `AFM_STATUS_OFS) begin
                status_q <= (status_q & ~pwdata_i[3:0]) | events; // RULE_19
            end else begin
                status_q <= status_q | events; // RULE_19
            end
            // Only a newly set bit pulses, so a fault that holds reports once
            fault_event_o <= |(events & ~status_q); // RULE_19
        end
    end

    assign following_fault_o          = status_q[`AFM_ST_FOLL_BIT];
    assign critical_following_fault_o = status_q[`AFM_ST_CRIT_BIT];
    assign rms_fault_o                = status_q[`AFM_ST_DRMS_BIT] | status_q[`AFM_ST_MRMS_BIT];
    assign irq_o                      = |(status_q & mask_q);

    // Control and interrupt mask
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `AFM_CTRL_RST;
            mask_q <= '0;
        end else if (wr_en) begin
            case (paddr_i)
                `AFM_CTRL_OFS: ctrl_q <= pwdata_i & `AFM_CTRL_WMASK;
                `AFM_MASK_OFS: mask_q <= pwdata_i[3:0];
                default: ;
            endcase
        end
    end

    // Critical thresholds: idle, cruise, accel
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            crit_thr_q[0] <= POS_W'(`AFM_CRIT_RST); // RULE_12
            crit_thr_q[1] <= POS_W'(`AFM_CRIT_RST);
            crit_thr_q[2] <= POS_W'(`AFM_CRIT_RST);
        end else if (wr_en) begin
            case (paddr_i)
                `AFM_ICRIT_OFS: crit_thr_q[0] <= POS_W'(pwdata_i);
                `AFM_CCRIT_OFS: crit_thr_q[1] <= POS_W'(pwdata_i);
                `AFM_ACRIT_OFS: crit_thr_q[2] <= POS_W'(pwdata_i);
                default: ;
            endcase
        end
    end

    // Normal thresholds: idle, cruise, accel
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            foll_thr_q[0] <= POS_W'(`AFM_FOLL_RST); // RULE_12
            foll_thr_q[1] <= POS_W'(`AFM_FOLL_RST);
            foll_thr_q[2] <= POS_W'(`AFM_FOLL_RST);
        end else if (wr_en) begin
            case (paddr_i)
                `AFM_IFOLL_OFS: foll_thr_q[0] <= POS_W'(pwdata_i);
                `AFM_CFOLL_OFS: foll_thr_q[1] <= POS_W'(pwdata_i);
                `AFM_AFOLL_OFS: foll_thr_q[2] <= POS_W'(pwdata_i);
                default: ;
            endcase
        end
    end

    // Hold-off delays in milliseconds
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            idle_holdoff_delay_q   <= `AFM_DEL_RST;
            cruise_holdoff_delay_q <= `AFM_DEL_RST;
        end else if (wr_en) begin
            case (paddr_i)
                `AFM_IDEL_OFS: idle_holdoff_delay_q   <= pwdata_i[15:0];
                `AFM_CDEL_OFS: cruise_holdoff_delay_q <= pwdata_i[15:0];
                default: ;
            endcase
        end
    end

    // RMS limits and time constants; current limits are trusted to be ordered by software
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            drive_rms_limit_q         <= `AFM_RMS_LIM_RST;
            motor_rms_limit_q         <= `AFM_RMS_LIM_RST;
            drive_rms_time_constant_q <= `AFM_RMS_TC_RST;
            motor_rms_time_constant_q <= `AFM_RMS_TC_RST;
        end else if (wr_en) begin
            case (paddr_i)
                `AFM_DRMS_LIM_OFS: drive_rms_limit_q         <= pwdata_i[15:0];
                `AFM_MRMS_LIM_OFS: motor_rms_limit_q         <= pwdata_i[15:0];
                `AFM_DRMS_TC_OFS:  drive_rms_time_constant_q <= pwdata_i[15:0];
                `AFM_MRMS_TC_OFS:  motor_rms_time_constant_q <= pwdata_i[15:0];
                default: ;
            endcase
        end
    end

    // Read path, registered; unmapped reads give zero and an error response
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `AFM_MRMS_TC_OFS);
    endfunction

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                `AFM_CTRL_OFS:     prdata_o <= ctrl_q;
                `AFM_STATUS_OFS:   prdata_o <= {28'h000_0000, status_q};
                `AFM_MASK_OFS:     prdata_o <= {28'h000_0000, mask_q};
                `AFM_ERR_OFS:      prdata_o <= 32'(err_q);
                `AFM_ICRIT_OFS:    prdata_o <= 32'(crit_thr_q[0]);
                `AFM_CCRIT_OFS:    prdata_o <= 32'(crit_thr_q[1]);
                `AFM_ACRIT_OFS:    prdata_o <= 32'(crit_thr_q[2]);
                `AFM_IFOLL_OFS:    prdata_o <= 32'(foll_thr_q[0]);
                `AFM_CFOLL_OFS:    prdata_o <= 32'(foll_thr_q[1]);
                `AFM_AFOLL_OFS:    prdata_o <= 32'(foll_thr_q[2]);
                `AFM_IDEL_OFS:     prdata_o <= {16'h0000, idle_holdoff_delay_q};
                `AFM_CDEL_OFS:     prdata_o <= {16'h0000, cruise_holdoff_delay_q};
                `AFM_DRMS_LIM_OFS: prdata_o <= {16'h0000, drive_rms_limit_q};
                `AFM_MRMS_LIM_OFS: prdata_o <= {16'h0000, motor_rms_limit_q};
                `AFM_DRMS_TC_OFS:  prdata_o <= {16'h0000, drive_rms_time_constant_q};
                `AFM_MRMS_TC_OFS:  prdata_o <= {16'h0000, motor_rms_time_constant_q};
                default:           prdata_o <= '0;
            endcase
        end
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);

endmodule
`default_nettype wire

// [pkg/afm_params.svh]
// Offsets, field positions, reset values and timing constants of the axis fault monitor
`ifndef AFM_PARAMS_SVH
`define AFM_PARAMS_SVH

// Register byte offsets
`define AFM_CTRL_OFS          12'h000
`define AFM_STATUS_OFS        12'h004
`define AFM_MASK_OFS          12'h008
`define AFM_ERR_OFS           12'h00C
`define AFM_ICRIT_OFS         12'h010
`define AFM_CCRIT_OFS         12'h014
`define AFM_ACRIT_OFS         12'h018
`define AFM_IFOLL_OFS         12'h01C
`define AFM_CFOLL_OFS         12'h020
`define AFM_AFOLL_OFS         12'h024
`define AFM_IDEL_OFS          12'h028
`define AFM_CDEL_OFS          12'h02C
`define AFM_DRMS_LIM_OFS      12'h030
`define AFM_MRMS_LIM_OFS      12'h034
`define AFM_DRMS_TC_OFS       12'h038
`define AFM_MRMS_TC_OFS       12'h03C

// Control fields
`define AFM_CTRL_ALLOW_BIT    0
`define AFM_CTRL_DELAY_BIT    1
`define AFM_CTRL_WMASK        32'h0000_0003

// Status and mask fields
`define AFM_ST_FOLL_BIT       0
`define AFM_ST_CRIT_BIT       1
`define AFM_ST_DRMS_BIT       2
`define AFM_ST_MRMS_BIT       3

// Reset values
`define AFM_CTRL_RST          32'h0000_0003
`define AFM_CRIT_RST          32'h0000_03E8
`define AFM_FOLL_RST          32'h0000_0064
`define AFM_DEL_RST           16'h0032
`define AFM_RMS_LIM_RST       16'h0064
`define AFM_RMS_TC_RST        16'h0CE4

// Timing
`define AFM_CLK_HZ            25000000
`define AFM_MS_NS             1000000
`define AFM_CLK_NS            40
`define AFM_MS_CYCLES         (`AFM_MS_NS / `AFM_CLK_NS)

`endif

// [pkg/afm_pkg.sv]
// Types of the axis fault monitor
`default_nettype none
package afm_pkg;

    typedef enum logic [1:0] {
        AFM_IDLE,
        AFM_CRUISE,
        AFM_ACCEL
    } afm_motion_t;

endpackage
`default_nettype wire

// [testbench/afm_axis_fault_monitor_properties.sv]
// Port-level checks of the axis fault monitor, bound into the design
`timescale 1ns/100ps
`default_nettype none
module afm_axis_fault_monitor_properties #(
    parameter int POS_W  = 32,
    parameter int MS_CYC = 10
) (
    // Clock, reset and register bus
    input wire logic             mclk_i,
    input wire logic             rst_n_i,
    input wire logic             psel_i,
    input wire logic             penable_i,
    input wire logic             pwrite_i,
    input wire logic [11:0]      paddr_i,
    input wire logic [31:0]      pwdata_i,
    input wire logic [31:0]      prdata_o,
    input wire logic             pready_o,
    input wire logic             pslverr_o,
    // Motion side and faults
    input wire logic [POS_W-1:0] ref_position_i,
    input wire logic [POS_W-1:0] feedback_position_i,
    input wire logic [1:0]       motion_state_i,
    input wire logic [15:0]      drive_command_level_i,
    input wire logic             following_fault_o,
    input wire logic             critical_following_fault_o,
    input wire logic             rms_fault_o,
    input wire logic             fault_event_o,
    input wire logic             irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic wr_st = psel_i && penable_i && pwrite_i && paddr_i == 12'h004;
    wire logic any_f = following_fault_o || critical_following_fault_o || rms_fault_o;
    sequence s_access;
        psel_i && penable_i;
    endsequence
    // Error held at zero long enough that nothing can still be in flight
    sequence s_quiet_clear;
        (ref_position_i == feedback_position_i)[*3] ##0 (wr_st && pwdata_i[0]);
    endsequence
    a_access_ready: assert property (s_access |-> pready_o) else $error("access not ready");
    a_bad_addr_err: assert property (s_access |-> pslverr_o == (paddr_i > 12'h03C || paddr_i[1:0] != 2'b00))
        else $error("slave error wrong");
    a_foll_sticky: assert property (following_fault_o && !(wr_st && pwdata_i[0]) |=> following_fault_o)
        else $error("normal fault dropped");
    a_crit_sticky: assert property (critical_following_fault_o && !(wr_st && pwdata_i[1])
        |=> critical_following_fault_o) else $error("critical fault dropped");
    a_foll_event: assert property ($rose(following_fault_o) |-> fault_event_o)
        else $error("no event on normal fault");
    a_crit_event: assert property ($rose(critical_following_fault_o) |-> fault_event_o)
        else $error("no event on critical fault");
    a_event_cause: assert property (fault_event_o |-> any_f) else $error("event without fault");
    a_irq_source: assert property (irq_o |-> any_f) else $error("irq without fault");
    a_zero_err_quiet: assert property ($rose(following_fault_o)
        |-> $past(ref_position_i != feedback_position_i, 2)) else $error("fault with zero error");
    a_clear_drops: assert property (s_quiet_clear |=> !following_fault_o)
        else $error("clear ignored");
endmodule
bind afm_axis_fault_monitor afm_axis_fault_monitor_properties #(.POS_W(POS_W), .MS_CYC(MS_CYC)) afm_props_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ref_position_i(ref_position_i), .feedback_position_i(feedback_position_i),
    .motion_state_i(motion_state_i), .drive_command_level_i(drive_command_level_i),
    .following_fault_o(following_fault_o), .critical_following_fault_o(critical_following_fault_o),
    .rms_fault_o(rms_fault_o), .fault_event_o(fault_event_o), .irq_o(irq_o));
`default_nettype wire

// [testbench/afm_drive_model.sv]
// Behavioural drive, motor and encoder facing the monitor
`timescale 1ns/100ps
`default_nettype none
module afm_drive_model (
    // Trajectory and bench control
    input  wire logic        [31:0] ref_position_i,
    input  wire logic signed [31:0] lag_i,
    input  wire logic        [15:0] cmd_i,
    // Feedback to the monitor
    output logic             [31:0] feedback_position_o,
    output logic             [15:0] drive_command_level_o
);
    // Combinational so a new reference never shows a false one-cycle error
    assign feedback_position_o = ref_position_i - lag_i;
    // Command passes straight through at the level set by the bench, with no limit applied
    assign drive_command_level_o = cmd_i;
endmodule
`default_nettype wire

// [testbench/axis_fault_monitor_tb.sv]
// Self-checking bench for the axis fault monitor
`timescale 1ns/100ps
`default_nettype none
module axis_fault_monitor_tb;
    logic               mclk_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0000_0000, ref_pos = 32'h0000_0000, prdata, fb_pos;
    logic signed [31:0] lag = 0;
    logic [15:0]        cmd = 16'h0005, cmd_lvl;
    logic [1:0]         state = 2'b00;
    logic               pready, foll, crit, rms, irq, slverr, bus_err, evt;
    logic [31:0]        exp_q[$];
    int                 err_total = 0, checks = 0, seed = 99141, n, evt_cnt = 0;
    int                 foll_thr[3] = '{10, 20, 30};
    int                 crit_thr[3] = '{200, 300, 400};
    logic [31:0] rst_val[16] = '{32'h0000_0003, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_03E8, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_0064, 32'h0000_0064, 32'h0000_0064,
        32'h0000_0032, 32'h0000_0032, 32'h0000_0064, 32'h0000_0064, 32'h0000_0CE4, 32'h0000_0CE4};
    always #20 mclk_i = ~mclk_i;
    afm_axis_fault_monitor #(.MS_CYC(10)) afm_axis_fault_monitor_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(slverr), .ref_position_i(ref_pos),
        .feedback_position_i(fb_pos), .motion_state_i(state), .drive_command_level_i(cmd_lvl),
        .following_fault_o(foll), .critical_following_fault_o(crit), .rms_fault_o(rms),
        .fault_event_o(evt), .irq_o(irq));
    afm_drive_model afm_drive_model_i (.ref_position_i(ref_pos), .lag_i(lag), .cmd_i(cmd),
        .feedback_position_o(fb_pos), .drive_command_level_o(cmd_lvl));
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 16);
        bus_err = slverr;
        if (n >= 16) begin
            err_total++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // Fresh random reference each time; the error itself is set by the lag
    task automatic set_err(input logic signed [31:0] l);
        lag <= l;
        ref_pos <= $random(seed);
        repeat (4) @(posedge mclk_i);
    endtask
    task automatic clr();
        set_err(0);
        wr(12'h004, 32'h0000_000F);
    endtask
    always @(posedge mclk_i) begin
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
            check("prdata", prdata, exp_q.pop_front());
    end
    always @(posedge mclk_i) begin
        if (evt === 1'b1)
            evt_cnt++;
    end
    initial begin
        repeat (100000) @(posedge mclk_i);
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 16; i++) rd(12'(4 * i), rst_val[i]);
        rd(12'h040, 32'h0000_0000);
        check("pslverr", 32'(bus_err), 32'h0000_0001);
        wr(12'h000, 32'h0000_0001);
        check("pslverr", 32'(bus_err), 32'h0000_0000);
        for (int s = 0; s < 3; s++) begin
            wr(12'h01C + 12'(4 * s), 32'(foll_thr[s]));
            wr(12'h010 + 12'(4 * s), 32'(crit_thr[s]));
        end
        for (int s = 0; s < 3; s++) begin
            state <= 2'(s);
            set_err(foll_thr[s]);
            rd(12'h004, 32'h0000_0000);
            set_err(foll_thr[s] + 1);
            rd(12'h004, 32'h0000_0001);
            set_err(-crit_thr[s] - 1);
            rd(12'h004, 32'h0000_0003);
            check("faults", {30'h0, crit, foll}, 32'h0000_0003);
            clr();
        end
        wr(12'h000, 32'h0000_0000);
        state <= 2'b00;
        set_err(-crit_thr[0] - 1);
        rd(12'h004, 32'h0000_0002);
        wr(12'h008, 32'h0000_0002);
        repeat (2) @(posedge mclk_i);
        check("irq", 32'(irq), 32'h0000_0001);
        wr(12'h008, 32'h0000_0001);
        repeat (2) @(posedge mclk_i);
        check("irq", 32'(irq), 32'h0000_0000);
        wr(12'h008, 32'h0000_0002);
        clr();
        repeat (2) @(posedge mclk_i);
        check("irq", 32'(irq), 32'h0000_0000);
        // Short hold-off, still well past the read that follows the change
        wr(12'h000, 32'h0000_0003);
        wr(12'h028, 32'h0000_0003);
        wr(12'h02C, 32'h0000_0003);
        for (int s = 0; s < 2; s++) begin
            state <= 2'b10;
            set_err(0);
            state <= 2'(s);
            set_err(foll_thr[s] + 1);
            rd(12'h004, 32'h0000_0000);
            repeat (40) @(posedge mclk_i);
            rd(12'h004, 32'h0000_0001);
            clr();
        end
        wr(12'h034, 32'h0000_FFFF);
        wr(12'h030, 32'h0000_000A);
        wr(12'h038, 32'h0000_0001);
        repeat (60) @(posedge mclk_i);
        rd(12'h004, 32'h0000_0000);
        cmd <= 16'h0064;
        repeat (60) @(posedge mclk_i);
        rd(12'h004, 32'h0000_0004);
        check("rms", 32'(rms), 32'h0000_0001);
        wr(12'h034, 32'h0000_000A);
        wr(12'h03C, 32'h0000_0001);
        repeat (60) @(posedge mclk_i);
        rd(12'h004, 32'h0000_000C);
        check("events", 32'(evt_cnt), 32'h0000_000B);
        give_verdict();
    end
endmodule
`default_nettype wire
